//--- hw/tip_pkg.sv
package tip_pkg;

  // ---------------------------------------------------------------
  // Status longword layout
  // ---------------------------------------------------------------
  localparam int PSL_T = 4;
  localparam int PSL_IPL_LO = 16;
  localparam int PSL_IPL_HI = 20;
  localparam int PSL_CM_LO = 24;
  localparam int PSL_CM_HI = 25;
  localparam int PSL_IS = 26;
  localparam int PSL_TP = 30;
  localparam int PSW_HI = 15;
  localparam logic [31:0] PSL_RST = 32'h001f_0000;

  // ---------------------------------------------------------------
  // Priority levels and modes
  // ---------------------------------------------------------------
  localparam logic [4:0] IPL_BOOT = 5'h1f;
  localparam logic [4:0] IPL_NONE = 5'h00;
  localparam logic [4:0] IPL_AST = 5'h02;
  localparam logic [4:0] IPL_DEV_BASE = 5'h10;
  localparam logic [4:0] IPL_CONS = 5'h14;
  localparam logic [4:0] IPL_TIMER = 5'h18;
  localparam logic [4:0] IPL_PWRFAIL = 5'h1e;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam int DEV_LVLS = 8;
  localparam int SRC_CONS = 8;
  localparam int SRC_TIMER = 9;
  localparam int SRC_PWR = 10;
  localparam int SRC_AST = 11;
  localparam int NSRC = 12;
  localparam int NPIN = 11;
  localparam logic [15:0] VEC_BASE = 16'h0100;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IPL = 8'h00;
  localparam logic [7:0] ADDR_PSL = 8'h04;
  localparam logic [7:0] ADDR_REQ = 8'h08;
  localparam logic [7:0] ADDR_SRCEN = 8'h0c;
  localparam logic [7:0] ADDR_ASYNC_TRAP_LEVEL = 8'h10;
  localparam logic [7:0] SRCEN_RST = 8'hff;
  localparam logic [2:0] ASYNC_TRAP_LEVEL_RST = 3'h4;

  // ---------------------------------------------------------------
  // Save record kinds
  // ---------------------------------------------------------------
  localparam logic [2:0] SAVE_TRACE = 3'h1;
  localparam logic [2:0] SAVE_FAULT = 3'h2;
  localparam logic [2:0] SAVE_ABORT = 3'h3;
  localparam logic [2:0] SAVE_INT = 3'h4;
  localparam logic [2:0] SAVE_CHM = 3'h5;
  localparam logic [2:0] SAVE_CALL = 3'h6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic instr_start;
    logic instr_done;
    logic restart_pt;
    logic fault;
    logic abort;
    logic arith_trap;
    logic chm;
    logic exception_return_instr;
    logic call;
    logic status_bit_set_instr;
    logic rsvd_instr;
  } tip_evt_t;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [31:0] psl;
    logic [31:0] pc;
  } tip_save_t;

  typedef enum logic [1:0] {
    ST_BOUND = 2'b00,
    ST_EXEC = 2'b01
  } tip_state_t;

  // Fixed level of each request source
  function automatic logic [4:0] src_level(input int idx);
    if (idx < DEV_LVLS) begin
      src_level = IPL_DEV_BASE + 5'(idx);
    end else if (idx == SRC_CONS) begin
      src_level = IPL_CONS;
    end else if (idx == SRC_TIMER) begin
      src_level = IPL_TIMER;
    end else if (idx == SRC_PWR) begin
      src_level = IPL_PWRFAIL;
    end else begin
      src_level = IPL_AST;
    end
  endfunction : src_level

endpackage : tip_pkg

//--- hw/tip_trace_irq.sv
`timescale 1ns/1ps
// What this block does
// - One trace exception after each traced instruction; saved PC is next instruction.
// - Trace fault beats every other exception of that instruction.
// - At instruction start, pending trace is cleared then the trace fault taken.
// - After the start check, trace enable is copied into trace pending.
// - Fault or mid-instruction interrupt saves pending cleared and instruction start PC.
// - Abort or arithmetic trap saves trace pending unchanged.
// - Interrupt between instructions saves trace pending unchanged.
// - Change-mode clears both trace bits; saved copy gets both if enable was set.
// - Exception return sets pending if enable was set or restored pending set.
// - Enabling trace by status-bit-set first faults the second following instruction.
// - Reserved-instruction fault only after trace check; events clear pending first.
// - Whole status longword saved on entry, whole restored on exception return.
// - Serve request only above current level; raise level to request level.
// - Only kernel mode may write the priority level.
// - Interrupts start only at instruction boundaries or defined restart points.
// - Return to mode at or above trap level posts level 2 trap interrupt.
// - Console at 14, timer at 18, power failure at 1E hexadecimal.
// - Device requests use levels 10 through 17; subset allowed.
// - Each source has its own fixed vector address.
// - Interrupt entry leaves memory mapping untouched.
// - Level register write loads status bits 20:16; reads zero above.
// - Bootstrap sets current level to 1F.
module tip_trace_irq (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Execution pipeline
  input tip_pkg::tip_evt_t PIPE_EVT,
  input wire logic [31:0] PIPE_PC,
  input wire logic [31:0] PIPE_OPND,
  // Interrupt request pins
  input wire logic [7:0] DEV_IRQ,
  input wire logic CONS_IRQ,
  input wire logic TIMER_IRQ,
  input wire logic PWRFAIL_IRQ,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Exception and interrupt outputs
  output logic TRACE_FAULT,
  output logic RSVD_FAULT,
  output logic INT_TAKE,
  output logic [4:0] INT_LEVEL,
  output logic [15:0] INT_VECTOR,
  output tip_pkg::tip_save_t SAVE,
  output logic [31:0] PSL_OUT
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] psl_q;
  tip_pkg::tip_state_t state_q;
  tip_pkg::tip_save_t save_q;
  logic [tip_pkg::NPIN-1:0] sync1_q;
  logic [tip_pkg::NPIN-1:0] sync2_q;
  logic [7:0] srcen_q;
  logic [2:0] async_trap_level_q;
  logic ast_q;
  logic [31:0] rdata_q;
  logic trace_q;
  logic rsvd_q;
  logic take_q;
  logic [4:0] lvl_q;
  logic [15:0] vec_q;
  logic [tip_pkg::NSRC-1:0] req;
  logic [4:0] best_lvl;
  logic [3:0] best_id;
  logic [4:0] cur_ipl;
  logic [1:0] cur_mode;
  logic t_en;
  logic tp;
  logic svc_pt;
  logic go_int;
  logic go_start;
  logic go_fault;
  logic go_trap;
  logic go_chm;
  logic go_rei;
  logic go_call;
  logic go_bis;
  logic ipl_wr;
  logic ast_set;

  assign cur_ipl = psl_q[tip_pkg::PSL_IPL_HI:tip_pkg::PSL_IPL_LO];
  assign cur_mode = psl_q[tip_pkg::PSL_CM_HI:tip_pkg::PSL_CM_LO];
  assign t_en = psl_q[tip_pkg::PSL_T];
  assign tp = psl_q[tip_pkg::PSL_TP];

  // ---------------------------------------------------------------
  // Request pin synchronisers
  // ---------------------------------------------------------------
  // Two flops per request pin
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {PWRFAIL_IRQ, TIMER_IRQ, CONS_IRQ, DEV_IRQ};
      sync2_q <= sync1_q;
    end
  end

  // Enabled device levels plus fixed sources
  assign req = {ast_q, sync2_q[tip_pkg::NPIN-1:tip_pkg::DEV_LVLS],
                sync2_q[tip_pkg::DEV_LVLS-1:0] & srcen_q};

  // ---------------------------------------------------------------
  // Priority arbitration
  // ---------------------------------------------------------------
  // Highest level wins, lower index on a tie
  always_comb begin
    best_lvl = tip_pkg::IPL_NONE;
    best_id = '0;
    for (int i = 0; i < tip_pkg::NSRC; i++) begin
      if (req[i] && tip_pkg::src_level(i) > best_lvl) begin
        best_lvl = tip_pkg::src_level(i);
        best_id = 4'(i);
      end
    end
  end

  // Boundary, or restart point inside a long instruction
  assign svc_pt = (state_q == tip_pkg::ST_BOUND) || PIPE_EVT.restart_pt;

  // Event selection, interrupt first, then trace check
  assign go_int = svc_pt && (best_lvl > cur_ipl);
  assign go_start = !go_int && PIPE_EVT.instr_start;
  assign go_fault = !go_int && !go_start && PIPE_EVT.fault;
  assign go_trap = !go_int && !go_start && !go_fault && (PIPE_EVT.abort || PIPE_EVT.arith_trap);
  assign go_chm = !go_int && !go_start && !go_fault && !go_trap && PIPE_EVT.chm;
  assign go_rei = !go_int && !go_start && !go_fault && !go_trap && !go_chm && PIPE_EVT.exception_return_instr;
  assign go_call = !go_int && !go_start && !go_fault && !go_trap && !go_chm && !go_rei
                   && PIPE_EVT.call;
  assign go_bis = !go_int && !go_start && !go_fault && !go_trap && !go_chm && !go_rei
                  && !go_call && PIPE_EVT.status_bit_set_instr;
  assign ipl_wr = REG_WR && (REG_ADDR == tip_pkg::ADDR_IPL) && !go_int
                  && (cur_mode == tip_pkg::MODE_KERNEL);
  assign ast_set = go_rei && !PIPE_OPND[tip_pkg::PSL_IS]
                   && ({1'b0, PIPE_OPND[tip_pkg::PSL_CM_HI:tip_pkg::PSL_CM_LO]} >= async_trap_level_q);

  // ---------------------------------------------------------------
  // Instruction phase tracking
  // ---------------------------------------------------------------
  // Executing between start and done, else at a boundary
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_q <= tip_pkg::ST_BOUND;
    end else begin
      case (state_q)
        tip_pkg::ST_BOUND: begin
          if (go_start && !tp && !PIPE_EVT.rsvd_instr) begin
            state_q <= tip_pkg::ST_EXEC;
          end
        end
        tip_pkg::ST_EXEC: begin
          if (go_int || PIPE_EVT.instr_done || go_fault || go_trap) begin
            state_q <= tip_pkg::ST_BOUND;
          end
        end
        default: begin
          state_q <= tip_pkg::ST_BOUND;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Live status longword
  // ---------------------------------------------------------------
  // Trace bits and level updated per event
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      psl_q <= tip_pkg::PSL_RST;
    end else begin
      if (go_int) begin
        // Handler untraced; mapping state lives elsewhere and is left as is
        psl_q[tip_pkg::PSL_IPL_HI:tip_pkg::PSL_IPL_LO] <= best_lvl;
        psl_q[tip_pkg::PSL_T] <= 1'b0;
        psl_q[tip_pkg::PSL_TP] <= 1'b0;
        psl_q[tip_pkg::PSL_IS] <= 1'b1;
      end else if (go_start) begin
        if (tp || PIPE_EVT.rsvd_instr) begin
          psl_q[tip_pkg::PSL_T] <= 1'b0;
          psl_q[tip_pkg::PSL_TP] <= 1'b0;
        end else begin
          psl_q[tip_pkg::PSL_TP] <= t_en;
        end
      end else if (go_fault || go_trap) begin
        psl_q[tip_pkg::PSL_T] <= 1'b0;
        psl_q[tip_pkg::PSL_TP] <= 1'b0;
      end else if (go_chm) begin
        psl_q[tip_pkg::PSL_T] <= 1'b0;
        psl_q[tip_pkg::PSL_TP] <= 1'b0;
        psl_q[tip_pkg::PSL_CM_HI:tip_pkg::PSL_CM_LO] <= PIPE_OPND[1:0];
      end else if (go_rei) begin
        psl_q <= PIPE_OPND;
        psl_q[tip_pkg::PSL_TP] <= PIPE_OPND[tip_pkg::PSL_TP] | t_en;
      end else if (go_bis) begin
        psl_q[tip_pkg::PSW_HI:0] <= psl_q[tip_pkg::PSW_HI:0]
                                     | PIPE_OPND[tip_pkg::PSW_HI:0];
      end
      if (ipl_wr) begin
        psl_q[tip_pkg::PSL_IPL_HI:tip_pkg::PSL_IPL_LO] <= REG_WDATA[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Save record for the stack writer
  // ---------------------------------------------------------------
  // One-cycle record of longword and PC to push
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      save_q <= '0;
    end else begin
      save_q.valid <= go_int || go_start && (tp || PIPE_EVT.rsvd_instr) || go_fault
                      || go_trap || go_chm || go_call;
      save_q.pc <= PIPE_PC;
      save_q.psl <= psl_q;
      save_q.kind <= tip_pkg::SAVE_FAULT;
      if (go_int) begin
        save_q.kind <= tip_pkg::SAVE_INT;
        if (state_q == tip_pkg::ST_EXEC) begin
          save_q.psl[tip_pkg::PSL_TP] <= 1'b0;
        end
      end else if (go_start) begin
        save_q.psl[tip_pkg::PSL_TP] <= 1'b0;
        save_q.kind <= tp ? tip_pkg::SAVE_TRACE : tip_pkg::SAVE_FAULT;
      end else if (go_fault) begin
        save_q.psl[tip_pkg::PSL_TP] <= 1'b0;
      end else if (go_trap) begin
        save_q.kind <= tip_pkg::SAVE_ABORT;
      end else if (go_chm) begin
        save_q.kind <= tip_pkg::SAVE_CHM;
        save_q.psl[tip_pkg::PSL_T] <= t_en;
        save_q.psl[tip_pkg::PSL_TP] <= t_en;
      end else if (go_call) begin
        save_q.kind <= tip_pkg::SAVE_CALL;
        save_q.psl[tip_pkg::PSL_T] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Exception and interrupt pulses
  // ---------------------------------------------------------------
  // Trace before reserved-instruction check
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      trace_q <= 1'b0;
      rsvd_q <= 1'b0;
    end else begin
      trace_q <= go_start && tp;
      rsvd_q <= go_start && !tp && PIPE_EVT.rsvd_instr;
    end
  end

  // Interrupt grant with level and fixed vector
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      take_q <= 1'b0;
      lvl_q <= tip_pkg::IPL_NONE;
      vec_q <= '0;
    end else begin
      take_q <= go_int;
      if (go_int) begin
        lvl_q <= best_lvl;
        vec_q <= tip_pkg::VEC_BASE + {10'h000, best_id, 2'b00};
      end
    end
  end

  // Trap-delivery request, set beats clear
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ast_q <= 1'b0;
    end else if (ast_set) begin
      ast_q <= 1'b1;
    end else if (go_int && (best_id == 4'(tip_pkg::SRC_AST))) begin
      ast_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Writable configuration
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      srcen_q <= tip_pkg::SRCEN_RST;
      async_trap_level_q <= tip_pkg::ASYNC_TRAP_LEVEL_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == tip_pkg::ADDR_SRCEN) begin
        srcen_q <= REG_WDATA[7:0];
      end
      if (REG_ADDR == tip_pkg::ADDR_ASYNC_TRAP_LEVEL) begin
        async_trap_level_q <= REG_WDATA[2:0];
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (REG_RD) begin
        case (REG_ADDR)
          tip_pkg::ADDR_IPL: rdata_q <= {27'h0000000, cur_ipl};
          tip_pkg::ADDR_PSL: rdata_q <= psl_q;
          tip_pkg::ADDR_REQ: rdata_q <= {20'h00000, req};
          tip_pkg::ADDR_SRCEN: rdata_q <= {24'h000000, srcen_q};
          tip_pkg::ADDR_ASYNC_TRAP_LEVEL: rdata_q <= {29'h00000000, async_trap_level_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign REG_RDATA = rdata_q;
  assign TRACE_FAULT = trace_q;
  assign RSVD_FAULT = rsvd_q;
  assign INT_TAKE = take_q;
  assign INT_LEVEL = lvl_q;
  assign INT_VECTOR = vec_q;
  assign SAVE = save_q;
  assign PSL_OUT = psl_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_boot_level: assert property (@(posedge CLK_SYS) !RSTN |=> cur_ipl == tip_pkg::IPL_BOOT)
    else $error("level not 1F after reset");

  a_trace_once: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_start && tp |=> TRACE_FAULT && !tp && !RSVD_FAULT
      && SAVE.valid && SAVE.pc == $past(PIPE_PC) && !SAVE.psl[tip_pkg::PSL_TP])
    else $error("trace fault not taken once");

  a_tp_copy: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_start && !tp && !PIPE_EVT.rsvd_instr |=> tp == $past(t_en) && !TRACE_FAULT)
    else $error("pending not loaded from enable");

  a_fault_clear: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_fault |=> SAVE.valid && !SAVE.psl[tip_pkg::PSL_TP] && SAVE.pc == $past(PIPE_PC))
    else $error("fault save kept pending");

  a_abort_keep: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_trap |=> SAVE.psl[tip_pkg::PSL_TP] == $past(tp) && SAVE.kind == tip_pkg::SAVE_ABORT)
    else $error("abort save changed pending");

  a_bound_int: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_int && state_q == tip_pkg::ST_BOUND |=> SAVE.psl == $past(psl_q) && INT_TAKE)
    else $error("boundary interrupt altered saved longword");

  a_chm_bits: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_chm |=> !t_en && !tp && SAVE.psl[tip_pkg::PSL_TP] == $past(t_en)
      && SAVE.psl[tip_pkg::PSL_T] == $past(t_en))
    else $error("change-mode trace bits wrong");

  a_rei_pend: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_rei && (t_en || PIPE_OPND[tip_pkg::PSL_TP]) && !ipl_wr |=> tp)
    else $error("return did not set pending");

  a_call_clear: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    go_call |=> !SAVE.psl[tip_pkg::PSL_T] && t_en == $past(t_en))
    else $error("call saved trace bit");

  a_int_level: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    INT_TAKE |-> INT_LEVEL > $past(cur_ipl) && cur_ipl == INT_LEVEL)
    else $error("interrupt taken at or below level");

  a_user_ipl: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    REG_WR && REG_ADDR == tip_pkg::ADDR_IPL && cur_mode != tip_pkg::MODE_KERNEL
      && !go_int && !go_rei |=> $stable(cur_ipl))
    else $error("level written outside kernel");

  a_ast_post: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ast_set |=> ast_q)
    else $error("trap delivery not posted");

endmodule : tip_trace_irq

//--- test/tip_irq_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Request sources on the far side
// ----------------------------------------
module tip_irq_model (
  // Clock
  input wire logic clk_sys,
  // Processor acknowledge
  input wire logic int_take,
  input wire logic [15:0] int_vector,
  // Request pins
  output logic [7:0] dev_irq,
  output logic cons_irq,
  output logic timer_irq,
  output logic pwrfail_irq
);
  logic [10:0] pend_q = 11'h000;
  logic [15:0] ack_id;
  // One level request per source
  assign dev_irq = pend_q[7:0];
  assign {pwrfail_irq, timer_irq, cons_irq} = pend_q[10:8];
  assign ack_id = (int_vector - tip_pkg::VEC_BASE) >> 2;
  // Source drops its request once its own vector is taken
  always @(posedge clk_sys) begin
    if (int_take && ack_id < 16'h000b) begin
      pend_q[ack_id[3:0]] <= 1'b0;
    end
  end
  // Raise one request
  task automatic post(input int id);
    @(posedge clk_sys);
    pend_q[id] <= 1'b1;
  endtask : post
  // Drop every request
  task automatic clear_all();
    @(posedge clk_sys);
    pend_q <= 11'h000;
  endtask : clear_all
endmodule : tip_irq_model

//--- test/trace_and_interrupt_priority_tb.sv
`timescale 1ns/1ps
module trace_and_interrupt_priority_tb;
  // Event masks in struct field order
  localparam logic [10:0] E_START = 11'h400;
  localparam logic [10:0] E_DONE = 11'h200;
  localparam logic [10:0] E_RESTART = 11'h100;
  localparam logic [10:0] E_FAULT = 11'h080;
  localparam logic [10:0] E_ABORT = 11'h040;
  localparam logic [10:0] E_CHM = 11'h010;
  localparam logic [10:0] E_XRET = 11'h008;
  localparam logic [10:0] E_CALL = 11'h004;
  localparam logic [10:0] E_BIS = 11'h002;
  localparam logic [10:0] E_RSVD = 11'h001;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  tip_pkg::tip_evt_t pipe_evt = '0;
  logic [31:0] pipe_pc = 32'h0;
  logic [31:0] pipe_opnd = 32'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] dev_irq;
  logic cons_irq, timer_irq, pwrfail_irq, trace_fault, rsvd_fault, int_take, got;
  logic [31:0] reg_rdata, psl_out, rv;
  logic [4:0] int_level;
  logic [15:0] int_vector;
  tip_pkg::tip_save_t save;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  tip_trace_irq u_tip_trace_irq (.CLK_SYS(clk_sys), .RSTN(rstn), .PIPE_EVT(pipe_evt),
    .PIPE_PC(pipe_pc), .PIPE_OPND(pipe_opnd), .DEV_IRQ(dev_irq), .CONS_IRQ(cons_irq),
    .TIMER_IRQ(timer_irq), .PWRFAIL_IRQ(pwrfail_irq), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .TRACE_FAULT(trace_fault), .RSVD_FAULT(rsvd_fault), .INT_TAKE(int_take),
    .INT_LEVEL(int_level), .INT_VECTOR(int_vector), .SAVE(save), .PSL_OUT(psl_out));
  tip_irq_model u_tip_irq_model (.clk_sys(clk_sys), .int_take(int_take),
    .int_vector(int_vector), .dev_irq(dev_irq), .cons_irq(cons_irq),
    .timer_irq(timer_irq), .pwrfail_irq(pwrfail_irq));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  always #4 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd
  // Event pulse; outputs are looked at in the answer cycle
  task automatic ev(input logic [10:0] e, input logic [31:0] o, input logic [31:0] pc);
    @(posedge clk_sys);
    pipe_evt <= tip_pkg::tip_evt_t'(e);
    pipe_opnd <= o;
    pipe_pc <= pc;
    @(posedge clk_sys);
    pipe_evt <= '0;
    #1;
  endtask : ev
  // One instruction that turns trace enable on
  task automatic bis_instr();
    ev(E_START, 0, 32'h80);
    ev(E_BIS, 32'h10, 0);
    ev(E_DONE, 0, 0);
  endtask : bis_instr
  task automatic wait_int();
    got = 1'b0;
    for (int i = 0; i < 12 && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = (int_take === 1'b1);
    end
  endtask : wait_int

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(psl_out, tip_pkg::PSL_RST);
    rd(tip_pkg::ADDR_IPL);
    chk(rv, 32'h1f);
    rd(8'h40);
    chk(rv, 32'h0);
    wr(tip_pkg::ADDR_IPL, 32'hffff_ffe3);
    rd(tip_pkg::ADDR_IPL);
    chk(rv, 32'h03);
    chk(32'(psl_out[20:16]), 32'h03);
    $display("test reset done");
  endtask : t_reset
  task automatic t_trace();
    bis_instr();
    ev(E_START, 0, 32'h100);
    chk(32'(trace_fault), 0);
    chk(32'(psl_out[tip_pkg::PSL_TP]), 1);
    ev(E_DONE, 0, 0);
    ev(E_START, 0, 32'h104);
    chk(32'(trace_fault), 1);
    chk(32'({save.valid, save.kind}), 32'({1'b1, tip_pkg::SAVE_TRACE}));
    chk(save.pc, 32'h104);
    chk(32'(save.psl[tip_pkg::PSL_TP]), 0);
    ev(E_DONE, 0, 0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        bis_instr();
        ev(E_START, 0, 32'h108);
        ev(E_DONE, 0, 0);
      end
      ev(E_START | E_RSVD, 0, 32'h10c);
      chk(32'({trace_fault, rsvd_fault}), (k == 1) ? 2 : 1);
      ev(E_DONE, 0, 0);
    end
    $display("test trace done");
  endtask : t_trace
  task automatic t_fault();
    for (int k = 0; k < 2; k++) begin
      bis_instr();
      ev(E_START, 0, 32'h200);
      ev(k ? E_ABORT : E_FAULT, 0, 32'h200);
      chk(32'(save.kind), 32'(k ? tip_pkg::SAVE_ABORT : tip_pkg::SAVE_FAULT));
      chk(32'(save.psl[tip_pkg::PSL_TP]), k);
      if (k == 0) begin
        chk(save.pc, 32'h200);
      end
    end
    $display("test fault done");
  endtask : t_fault
  task automatic t_mode();
    ev(E_START, 0, 32'h300);
    ev(E_BIS, 32'h10, 0);
    ev(E_CALL, 0, 0);
    chk(32'(save.kind), 32'(tip_pkg::SAVE_CALL));
    chk(32'({save.psl[tip_pkg::PSL_T], psl_out[tip_pkg::PSL_T]}), 1);
    ev(E_CHM, 0, 0);
    chk(32'(save.kind), 32'(tip_pkg::SAVE_CHM));
    chk(32'({save.psl[tip_pkg::PSL_TP], save.psl[tip_pkg::PSL_T]}), 3);
    chk(32'({psl_out[tip_pkg::PSL_TP], psl_out[tip_pkg::PSL_T]}), 0);
    ev(E_DONE, 0, 0);
    $display("test mode done");
  endtask : t_mode
  task automatic t_irq();
    int ids [3] = '{2, 9, 10};
    logic [4:0] lv [4] = '{5'h11, 5'h12, 5'h18, 5'h1e};
    wr(tip_pkg::ADDR_IPL, 32'h11);
    u_tip_irq_model.post(0);
    wait_int();
    chk(32'(got), 0);
    for (int i = 0; i < 3; i++) begin
      u_tip_irq_model.post(ids[i]);
      wait_int();
      chk(32'(got), 1);
      chk(32'(int_level), 32'(lv[i + 1]));
      chk(32'(int_vector), 32'h100 + 32'(4 * ids[i]));
      chk(32'(psl_out[20:16]), 32'(lv[i + 1]));
      chk(32'({save.kind, save.psl[20:16]}), 32'({tip_pkg::SAVE_INT, lv[i]}));
    end
    u_tip_irq_model.post(8);
    wait_int();
    chk(32'(got), 0);
    u_tip_irq_model.clear_all();
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_xret();
    wr(tip_pkg::ADDR_ASYNC_TRAP_LEVEL, 32'h3);
    ev(E_START, 0, 32'h400);
    ev(E_XRET, 32'h401f_0000, 0);
    chk(psl_out, 32'h401f_0000);
    ev(E_DONE, 0, 0);
    ev(E_START, 0, 32'h404);
    chk(32'(trace_fault), 1);
    ev(E_DONE, 0, 0);
    ev(E_START, 0, 32'h408);
    ev(E_XRET, 32'h0300_0000, 0);
    chk(psl_out, 32'h0300_0000);
    wr(tip_pkg::ADDR_IPL, 32'h1f);
    rd(tip_pkg::ADDR_IPL);
    chk(rv, 32'h0);
    ev(E_DONE, 0, 0);
    wait_int();
    chk(32'({got, int_level}), 32'h22);
    chk(32'(int_vector), 32'h12c);
    $display("test exception return done");
  endtask : t_xret
  // Masked device level, then service at a restart point mid-instruction
  task automatic t_misc();
    ev(E_XRET, 32'h0, 0);
    wr(tip_pkg::ADDR_SRCEN, 32'hfb);
    wr(tip_pkg::ADDR_IPL, 32'h10);
    u_tip_irq_model.post(2);
    wait_int();
    chk(32'(got), 0);
    rd(tip_pkg::ADDR_REQ);
    chk(rv, 32'h0);
    bis_instr();
    ev(E_START, 0, 32'h500);
    wr(tip_pkg::ADDR_SRCEN, 32'hff);
    rd(tip_pkg::ADDR_REQ);
    chk(rv, 32'h4);
    wait_int();
    chk(32'(got), 0);
    ev(E_RESTART, 0, 32'h504);
    chk(32'(int_take), 1);
    chk(save.pc, 32'h504);
    chk(32'({save.kind, save.psl[tip_pkg::PSL_TP]}), 32'({tip_pkg::SAVE_INT, 1'b0}));
    u_tip_irq_model.clear_all();
    $display("test restart point done");
  endtask : t_misc

  // Reset, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_trace();
    t_fault();
    t_mode();
    t_irq();
    t_xret();
    t_misc();
    finish_test();
  end
endmodule : trace_and_interrupt_priority_tb
